// file: core/io_decode_regs.vh
// Constants for the host I/O decode slice: address bus width and port addresses.
// Assumes an 11-bit I/O address bus and active-low bus strobes.
// What this block does
// - Decode processor cycles only while address enable is low.
// - A low read or write strobe marks an active access.
// - DMA channel 2 acknowledge is active low.
// - High system reset holds reset state; low resumes operation.
// - Write to 378 or 3BC hex pulses printer data latch low.
// - Read of 201 hex holds joystick read strobe low throughout the read.
// - Write to 201 hex drives joystick trigger low.
// - Provide enable for external transceiver on the eight data lines.
// - Range select high picks 378-37A hex, low picks 3BC-3BF hex.
// - Printer enable low suppresses every printer decode and strobe.
`ifndef IO_DECODE_REGS_VH
`define IO_DECODE_REGS_VH
`define ADDR_W 11
`define JOY_ADDR 11'h201
`define LPT_PRI_BASE 11'h378
`define LPT_PRI_LAST 11'h37A
`define LPT_ALT_BASE 11'h3BC
`define LPT_ALT_LAST 11'h3BF
`endif

// file: core/addr_range_match.v
// Inclusive address range comparator.
// Assumes address and bounds share one width.
`timescale 1ns/1ps
`default_nettype none
module addr_range_match #(
  parameter [10:0] LOW = 11'h000,
  parameter [10:0] HIGH = 11'h000
) (
  input wire [10:0] addr,
  output wire hit
);
  assign hit = (addr >= LOW) && (addr <= HIGH);
endmodule
`default_nettype wire

// file: core/io_bus_decode.v
// Host bus qualification and decode for printer latch, joystick port and transceiver.
// Assumes bus inputs already synchronous to clock; outputs lag the bus by one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "io_decode_regs.vh"
module io_bus_decode (
  input wire clock,
  input wire rst_b,
  input wire sys_reset,
  input wire [10:0] addr,
  input wire aen_n,
  input wire ior_n,
  input wire iow_n,
  input wire dack2_n,
  input wire printer_port_enable,
  input wire printer_range_select,
  output reg printer_data_latch_n,
  output reg joystick_read_n,
  output reg joystick_trigger_n,
  output reg transceiver_enable_n,
  output reg transceiver_to_bus,
  output reg dma2_active,
  output reg io_active_n
);

  // Printer decode windows, one comparator each
  localparam N_RANGE = 2;
  localparam RANGE_PRI = 0;
  localparam RANGE_ALT = 1;

  wire [N_RANGE-1:0] range_hit;
  wire in_reset;
  wire cpu_cycle;
  wire rd;
  wire wr;
  reg lpt_hit;
  reg lpt_data;
  reg joy_hit;
  reg own_hit;
  reg printer_data_latch_n_nxt;
  reg joystick_read_n_nxt;
  reg joystick_trigger_n_nxt;
  reg transceiver_enable_n_nxt;
  reg transceiver_to_bus_nxt;
  reg dma2_active_nxt;
  reg io_active_n_nxt;

  genvar i;
  generate
    for (i = 0; i < N_RANGE; i = i + 1)
    begin : range_gen
      addr_range_match #(
        .LOW(i == RANGE_PRI ? `LPT_PRI_BASE : `LPT_ALT_BASE),
        .HIGH(i == RANGE_PRI ? `LPT_PRI_LAST : `LPT_ALT_LAST)
      ) range_match (
        .addr(addr),
        .hit(range_hit[i])
      );
    end
  endgenerate

  // Bus qualification
  assign in_reset = sys_reset || !rst_b;
  assign cpu_cycle = !aen_n;
  assign rd = cpu_cycle && !ior_n;
  assign wr = cpu_cycle && !iow_n;

  // Range chosen by select, printer hits gated by enable; joystick hit is not
  always @*
  begin
    lpt_hit = 1'b0;
    lpt_data = 1'b0;
    joy_hit = 1'b0;
    own_hit = 1'b0;
    if (printer_port_enable)
    begin
      if (printer_range_select)
      begin
        lpt_hit = range_hit[RANGE_PRI];
        lpt_data = (addr == `LPT_PRI_BASE);
      end
      else
      begin
        lpt_hit = range_hit[RANGE_ALT];
        lpt_data = (addr == `LPT_ALT_BASE);
      end
    end
    if (addr == `JOY_ADDR)
    begin
      joy_hit = 1'b1;
    end
    if ((lpt_hit || joy_hit) && (rd || wr))
    begin
      own_hit = 1'b1;
    end
  end

  // Printer data latch strobe
  always @*
  begin
    if (wr && lpt_data)
    begin
      printer_data_latch_n_nxt = 1'b0;
    end
    else
    begin
      printer_data_latch_n_nxt = 1'b1;
    end
  end

  // Joystick read strobe, held for the whole read
  always @*
  begin
    if (rd && joy_hit)
    begin
      joystick_read_n_nxt = 1'b0;
    end
    else
    begin
      joystick_read_n_nxt = 1'b1;
    end
  end

  // Joystick one-shot trigger
  always @*
  begin
    if (wr && joy_hit)
    begin
      joystick_trigger_n_nxt = 1'b0;
    end
    else
    begin
      joystick_trigger_n_nxt = 1'b1;
    end
  end

  // Transceiver only for our own decoded cycles
  always @*
  begin
    if (own_hit)
    begin
      transceiver_enable_n_nxt = 1'b0;
    end
    else
    begin
      transceiver_enable_n_nxt = 1'b1;
    end
  end

  // Direction toward system bus on reads
  always @*
  begin
    if (rd)
    begin
      transceiver_to_bus_nxt = 1'b1;
    end
    else
    begin
      transceiver_to_bus_nxt = 1'b0;
    end
  end

  // DMA channel 2 acknowledge seen
  always @*
  begin
    if (!dack2_n)
    begin
      dma2_active_nxt = 1'b1;
    end
    else
    begin
      dma2_active_nxt = 1'b0;
    end
  end

  // Any bus strobe low, regardless of address enable
  always @*
  begin
    if (!ior_n || !iow_n)
    begin
      io_active_n_nxt = 1'b0;
    end
    else
    begin
      io_active_n_nxt = 1'b1;
    end
  end

  // Decode strobes
  always @(posedge clock)
  begin
    if (in_reset)
    begin
      printer_data_latch_n <= 1'b1;
      joystick_read_n <= 1'b1;
      joystick_trigger_n <= 1'b1;
    end
    else
    begin
      printer_data_latch_n <= printer_data_latch_n_nxt;
      joystick_read_n <= joystick_read_n_nxt;
      joystick_trigger_n <= joystick_trigger_n_nxt;
    end
  end

  // Transceiver control and bus status
  always @(posedge clock)
  begin
    if (in_reset)
    begin
      transceiver_enable_n <= 1'b1;
      transceiver_to_bus <= 1'b0;
      dma2_active <= 1'b0;
      io_active_n <= 1'b1;
    end
    else
    begin
      transceiver_enable_n <= transceiver_enable_n_nxt;
      transceiver_to_bus <= transceiver_to_bus_nxt;
      dma2_active <= dma2_active_nxt;
      io_active_n <= io_active_n_nxt;
    end
  end

endmodule
`default_nettype wire

// file: verif/io_bus_decode_sva.sv
// Port checker for io_bus_decode; bound below
`timescale 1ns/1ps
`default_nettype none
module dec_sva(input wire clock, rst_b, sys_reset, aen_n, ior_n, iow_n, dack2_n,
  printer_port_enable, printer_range_select, printer_data_latch_n, joystick_read_n,
  joystick_trigger_n, transceiver_enable_n, transceiver_to_bus, dma2_active, io_active_n,
  input wire [10:0] addr);
  wire ok = rst_b & ~sys_reset;
  wire w = ~aen_n & ~iow_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!ok);
  AST_JT: assert property (w && addr == 11'h201 |=> !joystick_trigger_n) else $error("jt");
  AST_JR: assert property (!aen_n && !ior_n && addr == 11'h201 |=> !joystick_read_n) else $error("jr");
  AST_PL: assert property (w && printer_port_enable && addr == (printer_range_select ? 11'h378 :
    11'h3BC) |=> !printer_data_latch_n) else $error("pl");
  AST_AEN: assert property (aen_n |=> joystick_trigger_n && transceiver_enable_n) else $error("aen");
  AST_DMA: assert property ($fell(dack2_n) |=> dma2_active) else $error("dma");
  AST_IO: assert property (!(ior_n && iow_n) |=> !io_active_n) else $error("io");
  AST_TE: assert property (!transceiver_enable_n |-> transceiver_to_bus == $past(!ior_n)) else $error("te");
  AST_RST: assert property (disable iff (1'b0) !ok |=> joystick_read_n && !dma2_active) else $error("rst");
  cover property (!printer_data_latch_n);
  cover property (!joystick_read_n);
  cover property (dma2_active);
endmodule
bind io_bus_decode dec_sva dec_sva_inst(.*);
`default_nettype wire

// file: verif/bus_master.sv
// Bus master model; bench calls go, then idle
`timescale 1ns/1ps
`default_nettype none
module bus_master(input wire clock, output logic [10:0] addr, output logic aen_n, ior_n, iow_n, dack2_n);
  initial {addr, aen_n, ior_n, iow_n, dack2_n} = 15'h7FFF;
  task go(input [10:0] a, input rd, d);
    @(posedge clock) #1 {addr, aen_n, dack2_n, ior_n, iow_n} = {a, d, ~d, ~rd, rd};
  endtask
  task idle;
    @(posedge clock) #1 {addr, ior_n, iow_n, dack2_n} = {~addr, 3'h7};
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Bench for io_bus_decode driven by bus_master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 0, rst_b = 0, sys_reset = 0, printer_port_enable = 1, printer_range_select = 1;
  wire [10:0] addr;
  wire aen_n, ior_n, iow_n, dack2_n, printer_data_latch_n, joystick_read_n, joystick_trigger_n,
    transceiver_enable_n, transceiver_to_bus, dma2_active, io_active_n;
  int mismatches = 0, n_tests = 0;
  always #2.5 clock = ~clock;
  bus_master bus_master_inst(.*);
  io_bus_decode io_bus_decode_inst(.*);
  task results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t(input [10:0] a, input rd, d, pe, sel, rst, input [6:0] e);
    {printer_port_enable, printer_range_select, sys_reset} = {pe, sel, rst};
    bus_master_inst.go(a, rd, d);
    @(posedge clock) #2 n_tests++;
    if ({printer_data_latch_n, joystick_read_n, joystick_trigger_n, transceiver_enable_n,
      transceiver_to_bus, dma2_active, io_active_n} !== e) begin
      mismatches++;
      $display("wrong value at %0t: outputs for %h", $time, a);
    end
    bus_master_inst.idle;
    $display("test %h done", a);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_b = 1;
    t(11'h201, 0, 0, 1, 1, 0, 7'h60);
    t(11'h201, 1, 0, 1, 1, 0, 7'h54);
    t(11'h378, 0, 0, 1, 1, 0, 7'h30);
    t(11'h3BC, 0, 0, 1, 0, 0, 7'h30);
    t(11'h378, 0, 0, 1, 0, 0, 7'h78);
    t(11'h378, 0, 0, 0, 1, 0, 7'h78);
    t(11'h201, 0, 1, 1, 1, 0, 7'h7A);
    t(11'h201, 0, 0, 1, 1, 1, 7'h79);
    results;
  end
endmodule
`default_nettype wire
